// ### hw/tscr_regs.sv
// Tile status and control register bank
`timescale 1ns/1ps
module tscr_regs (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ps_wr_i,
	input wire logic ps_rd_i,
	input wire logic [7:0] ps_num_i,
	input wire logic [31:0] ps_wdata_i,
	output logic [31:0] ps_rdata_o,
	output logic ps_rvalid_o,
	output logic ps_werr_o,
	input wire logic ev_take_i,
	input wire logic [15:0] ev_vector_i,
	output logic [31:0] ev_target_o,
	output logic ev_target_valid_o,
	input wire logic [7:0] boot_proc_num_i,
	input wire logic boot_mode_override_i,
	input wire logic boot_no_otp_poll_i,
	input wire logic boot_from_ram_i,
	input wire logic boot_from_jtag_i,
	input wire logic [1:0] boot_pll_pin_state_i,
	input wire logic otp_load_i,
	input wire logic [31:0] otp_word_i,
	input wire logic [3:0] osc_line_i,
	output logic [1:0] extmem_size_o,
	output logic ram_shutdown_o,
	output logic mem_autosleep_o,
	output logic mipi_ports_on_o,
	output logic pll_divider_on_o,
	output logic extmem_on_o,
	output logic block_global_debug_o,
	output logic block_pll_boot_jtag_o,
	output logic block_debug_tap_o,
	output logic block_otp_reads_o,
	output logic block_otp_program_o,
	output logic otp_single_space_o,
	output logic force_otp_boot_o,
	output logic protection_write_lock_o,
	output logic core_oscillator_run_o,
	output logic peripheral_oscillator_run_o
);
	logic [31:0] vec_r;
	logic [31:0] ctrl_r;
	logic [31:0] boot_r;
	logic [31:0] prot_r;
	logic [31:0] run_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic rvalid_r;
	logic werr_r;
	logic werr_nxt;
	logic [31:0] target_r;
	logic target_valid_r;
	logic [3:0] osc_run;
	logic [tscr_pkg::CNT_W-1:0] osc_cnt [tscr_pkg::OSC_N];
	logic wr_vec;
	logic wr_ctrl;
	logic wr_prot;
	logic wr_run;

	assign wr_vec = ps_wr_i && (ps_num_i == tscr_pkg::NUM_VEC_BASE);
	assign wr_ctrl = ps_wr_i && (ps_num_i == tscr_pkg::NUM_TILE_CTRL);
	assign wr_prot = ps_wr_i && (ps_num_i == tscr_pkg::NUM_PROTECT);
	assign wr_run = ps_wr_i && (ps_num_i == tscr_pkg::NUM_OSC_RUN);

	// Vector base
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			vec_r <= tscr_pkg::VEC_RST;
		end else if (wr_vec) begin
			vec_r <= tscr_pkg::keep_bits(ps_wdata_i, tscr_pkg::VEC_MASK);
		end
	end

	// Branch target for a taken event or interrupt
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			target_r <= 32'h0000_0000;
			target_valid_r <= 1'b0;
		end else begin
			target_valid_r <= ev_take_i;
			if (ev_take_i) begin
				target_r <= {vec_r[31:tscr_pkg::VEC_HI_LSB], ev_vector_i};
			end
		end
	end

	// Tile feature control
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl_r <= tscr_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= tscr_pkg::keep_bits(ps_wdata_i, tscr_pkg::CTRL_MASK);
		end
	end

	// Boot state is caught from the straps while reset is held
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			boot_r <= 32'h0000_0000;
			boot_r[tscr_pkg::BOOT_PROC_LSB +: 8] <= boot_proc_num_i;
			boot_r[tscr_pkg::BOOT_OVERRIDE] <= boot_mode_override_i;
			boot_r[tscr_pkg::BOOT_NO_POLL] <= boot_no_otp_poll_i;
			boot_r[tscr_pkg::BOOT_RAM] <= boot_from_ram_i;
			boot_r[tscr_pkg::BOOT_JTAG] <= boot_from_jtag_i;
			boot_r[tscr_pkg::BOOT_PLL_LSB +: 2] <= boot_pll_pin_state_i;
		end
	end

	// Protection settings: OTP load wins over a software write
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			prot_r <= tscr_pkg::PROT_RST;
		end else if (otp_load_i) begin
			prot_r <= tscr_pkg::keep_bits(otp_word_i, tscr_pkg::PROT_MASK);
		end else if (wr_prot && !prot_r[tscr_pkg::PROT_LOCK]) begin
			prot_r <= tscr_pkg::keep_bits(ps_wdata_i, tscr_pkg::PROT_MASK);
		end
	end

	// Oscillator run control
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			run_r <= tscr_pkg::RUN_RST;
		end else if (wr_run) begin
			run_r <= tscr_pkg::keep_bits(ps_wdata_i, tscr_pkg::RUN_MASK);
		end
	end

	// Counters 0 and 1 sit in the tile, 2 and 3 in the peripheral area
	assign osc_run = {{2{run_r[tscr_pkg::RUN_PERIPH]}}, {2{run_r[tscr_pkg::RUN_CORE]}}};

	for (genvar g = 0; g < tscr_pkg::OSC_N; g++) begin : g_osc
		tscr_osc_counter u_cnt (
			.clk_i(clk_i),
			.run_i(osc_run[g]),
			.osc_i(osc_line_i[g]),
			.count_o(osc_cnt[g])
		);
	end

	// Read mux; unmapped numbers read zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		unique case (ps_num_i)
			tscr_pkg::NUM_VEC_BASE: rdata_nxt = vec_r;
			tscr_pkg::NUM_TILE_CTRL: rdata_nxt = ctrl_r;
			tscr_pkg::NUM_BOOT_STATE: rdata_nxt = boot_r;
			tscr_pkg::NUM_PROTECT: rdata_nxt = prot_r;
			tscr_pkg::NUM_OSC_RUN: rdata_nxt = run_r;
			tscr_pkg::NUM_OSC_CNT0: rdata_nxt = {16'h0000, osc_cnt[0]};
			tscr_pkg::NUM_OSC_CNT1: rdata_nxt = {16'h0000, osc_cnt[1]};
			tscr_pkg::NUM_OSC_CNT2: rdata_nxt = {16'h0000, osc_cnt[2]};
			tscr_pkg::NUM_OSC_CNT3: rdata_nxt = {16'h0000, osc_cnt[3]};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// A write to a read-only, unmapped or locked register is refused
	always_comb begin
		werr_nxt = 1'b0;
		if (ps_wr_i) begin
			werr_nxt = !(wr_vec || wr_ctrl || wr_run || wr_prot);
			if (wr_prot && prot_r[tscr_pkg::PROT_LOCK] && !otp_load_i) begin
				werr_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_r <= 32'h0000_0000;
			rvalid_r <= 1'b0;
			werr_r <= 1'b0;
		end else begin
			rvalid_r <= ps_rd_i;
			werr_r <= werr_nxt;
			if (ps_rd_i) begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	assign ps_rdata_o = rdata_r;
	assign ps_rvalid_o = rvalid_r;
	assign ps_werr_o = werr_r;
	assign ev_target_o = target_r;
	assign ev_target_valid_o = target_valid_r;

	assign extmem_size_o = ctrl_r[tscr_pkg::CTRL_SIZE_LSB +: 2];
	assign ram_shutdown_o = ctrl_r[tscr_pkg::CTRL_RAM_OFF];
	assign mem_autosleep_o = ctrl_r[tscr_pkg::CTRL_MEM_SLEEP];
	assign mipi_ports_on_o = ctrl_r[tscr_pkg::CTRL_MIPI_ON];
	assign pll_divider_on_o = ctrl_r[tscr_pkg::CTRL_PLL_DIV];
	assign extmem_on_o = ctrl_r[tscr_pkg::CTRL_EXTMEM_ON];

	assign block_global_debug_o = prot_r[tscr_pkg::PROT_GLOBAL_DBG];
	assign block_pll_boot_jtag_o = prot_r[tscr_pkg::PROT_PLL_JTAG];
	assign block_debug_tap_o = prot_r[tscr_pkg::PROT_DEBUG_TAP];
	assign block_otp_reads_o = prot_r[tscr_pkg::PROT_OTP_READ];
	assign block_otp_program_o = prot_r[tscr_pkg::PROT_OTP_PROG];
	assign otp_single_space_o = prot_r[tscr_pkg::PROT_OTP_MERGE];
	assign force_otp_boot_o = prot_r[tscr_pkg::PROT_OTP_BOOT];
	assign protection_write_lock_o = prot_r[tscr_pkg::PROT_LOCK];

	assign core_oscillator_run_o = run_r[tscr_pkg::RUN_CORE];
	assign peripheral_oscillator_run_o = run_r[tscr_pkg::RUN_PERIPH];

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	chk_target_form: assert property (
		ev_take_i |=> ev_target_valid_o
		&& ev_target_o == {$past(vec_r[31:16]), $past(ev_vector_i)})
		else $error("branch target not formed from base and vector");

	chk_vec_reserved: assert property (
		wr_vec |=> vec_r[18:0] == 19'h0 && vec_r[31:19] == $past(ps_wdata_i[31:19]))
		else $error("vector base field wrong");

	chk_ctrl_reset: assert property (
		$fell(reset_i) |-> extmem_size_o == 2'h3 && !ram_shutdown_o && !mem_autosleep_o
		&& !mipi_ports_on_o && !pll_divider_on_o && !extmem_on_o)
		else $error("control reset value wrong");

	chk_ctrl_write: assert property (
		wr_ctrl |=> ctrl_r == ($past(ps_wdata_i) & tscr_pkg::CTRL_MASK))
		else $error("control write not stored as masked");

	chk_boot_hold: assert property (
		!reset_i [*2] |-> $stable(boot_r))
		else $error("boot state changed outside reset");

	chk_boot_pins: assert property (
		$fell(reset_i) |-> boot_r[1:0] == $past(boot_pll_pin_state_i)
		&& boot_r[23:16] == $past(boot_proc_num_i))
		else $error("boot pins not captured");

	chk_otp_load: assert property (
		otp_load_i |=> prot_r == ($past(otp_word_i) & tscr_pkg::PROT_MASK))
		else $error("OTP word not loaded");

	chk_lock_hold: assert property (
		prot_r[31] && !otp_load_i |=> $stable(prot_r))
		else $error("locked protection register changed");

	chk_run_read: assert property (
		ps_rd_i && ps_num_i == 8'h06 |=> ps_rvalid_o
		&& ps_rdata_o == {30'h0, core_oscillator_run_o, peripheral_oscillator_run_o})
		else $error("run control read wrong");

	chk_count_read: assert property (
		ps_rd_i && ps_num_i == 8'h07 |=> ps_rdata_o[31:16] == 16'h0
		&& ps_rdata_o[15:0] == $past(osc_cnt[0]))
		else $error("count read wrong");

	chk_unmapped_zero: assert property (
		ps_rd_i && ps_num_i == 8'h04 |=> ps_rdata_o == 32'h0)
		else $error("unmapped read not zero");

	chk_ro_refused: assert property (
		ps_wr_i && ps_num_i == tscr_pkg::NUM_BOOT_STATE |=> ps_werr_o && $stable(boot_r))
		else $error("boot state write not refused");

	chk_vec_read: assert property (
		ps_rd_i && ps_num_i == tscr_pkg::NUM_VEC_BASE |=> ps_rdata_o[18:0] == 19'h0_0000)
		else $error("vector base reserved bits not zero");

	chk_size_write: assert property (
		wr_ctrl |=> extmem_size_o == $past(ps_wdata_i[12:11]))
		else $error("memory size field not stored");

	chk_feature_write: assert property (
		wr_ctrl |=> {ram_shutdown_o, mem_autosleep_o, mipi_ports_on_o, pll_divider_on_o,
		extmem_on_o} == {$past(ps_wdata_i[10:8]), $past(ps_wdata_i[4]), $past(ps_wdata_i[0])})
		else $error("feature control bits not stored");

	chk_boot_read: assert property (
		ps_rd_i && ps_num_i == tscr_pkg::NUM_BOOT_STATE |=> ps_rdata_o[31:24] == 8'h00
		&& ps_rdata_o[15:9] == 7'h00 && ps_rdata_o[7:5] == 3'h0)
		else $error("boot state reserved bits not zero");

	chk_prot_write: assert property (
		wr_prot && !prot_r[tscr_pkg::PROT_LOCK] && !otp_load_i
		|=> prot_r == ($past(ps_wdata_i) & tscr_pkg::PROT_MASK))
		else $error("protection write not stored as masked");

	chk_lock_refused: assert property (
		wr_prot && prot_r[tscr_pkg::PROT_LOCK] && !otp_load_i |=> ps_werr_o)
		else $error("write to locked protection register not refused");

	chk_prot_pins: assert property (
		otp_load_i |=> {block_global_debug_o, block_otp_reads_o, block_otp_program_o,
		otp_single_space_o, force_otp_boot_o, block_pll_boot_jtag_o, block_debug_tap_o}
		== {$past(otp_word_i[14]), $past(otp_word_i[9:7]), $past(otp_word_i[5:4]),
		$past(otp_word_i[0])})
		else $error("loaded security bits not on outputs");

	chk_run_write: assert property (
		wr_run |=> core_oscillator_run_o == $past(ps_wdata_i[1])
		&& peripheral_oscillator_run_o == $past(ps_wdata_i[0]))
		else $error("run control write not stored");

	chk_wire_read: assert property (
		ps_rd_i && ps_num_i == tscr_pkg::NUM_OSC_CNT1
		|=> ps_rdata_o == {16'h0000, $past(osc_cnt[1])})
		else $error("tile wire count read wrong");

	chk_periph_read: assert property (
		ps_rd_i && ps_num_i == tscr_pkg::NUM_OSC_CNT2
		|=> ps_rdata_o == {16'h0000, $past(osc_cnt[2])})
		else $error("peripheral cell count read wrong");

	chk_fourth_read: assert property (
		ps_rd_i && ps_num_i == tscr_pkg::NUM_OSC_CNT3
		|=> ps_rdata_o == {16'h0000, $past(osc_cnt[3])})
		else $error("fourth count read wrong");

	cov_event: cover property (ev_take_i ##1 ev_target_valid_o);
	cov_locked_write: cover property (wr_prot && prot_r[31]);
	cov_stop_read: cover property (wr_run ##[10:40] ps_rd_i && ps_num_i == 8'h09);
	cov_otp_lock: cover property (otp_load_i && otp_word_i[31]);
endmodule // tscr_regs

// ### hw/tscr_pkg.sv
// Register numbers, field layouts and reset values of the tile status bank
package tscr_pkg;
	localparam logic [7:0] NUM_VEC_BASE = 8'h01;
	localparam logic [7:0] NUM_TILE_CTRL = 8'h02;
	localparam logic [7:0] NUM_BOOT_STATE = 8'h03;
	localparam logic [7:0] NUM_PROTECT = 8'h05;
	localparam logic [7:0] NUM_OSC_RUN = 8'h06;
	localparam logic [7:0] NUM_OSC_CNT0 = 8'h07;
	localparam logic [7:0] NUM_OSC_CNT1 = 8'h08;
	localparam logic [7:0] NUM_OSC_CNT2 = 8'h09;
	localparam logic [7:0] NUM_OSC_CNT3 = 8'h0a;

	localparam logic [31:0] VEC_MASK = 32'hfff8_0000;
	localparam logic [31:0] VEC_RST = 32'h0000_0000;
	localparam int VEC_HI_LSB = 16;

	localparam int CTRL_EXTMEM_ON = 0;
	localparam int CTRL_PLL_DIV = 4;
	localparam int CTRL_MIPI_ON = 8;
	localparam int CTRL_MEM_SLEEP = 9;
	localparam int CTRL_RAM_OFF = 10;
	localparam int CTRL_SIZE_LSB = 11;
	localparam logic [31:0] CTRL_MASK = 32'h0000_1f11;
	localparam logic [31:0] CTRL_RST = 32'h0000_1800;

	localparam int BOOT_PLL_LSB = 0;
	localparam int BOOT_JTAG = 2;
	localparam int BOOT_RAM = 3;
	localparam int BOOT_NO_POLL = 4;
	localparam int BOOT_OVERRIDE = 8;
	localparam int BOOT_PROC_LSB = 16;

	localparam int PROT_DEBUG_TAP = 0;
	localparam int PROT_PLL_JTAG = 4;
	localparam int PROT_OTP_BOOT = 5;
	localparam int PROT_OTP_MERGE = 7;
	localparam int PROT_OTP_PROG = 8;
	localparam int PROT_OTP_READ = 9;
	localparam int PROT_GLOBAL_DBG = 14;
	localparam int PROT_LOCK = 31;
	localparam logic [31:0] PROT_MASK = 32'h8000_43b1;
	localparam logic [31:0] PROT_RST = 32'h0000_0000;

	localparam int RUN_PERIPH = 0;
	localparam int RUN_CORE = 1;
	localparam logic [31:0] RUN_MASK = 32'h0000_0003;
	localparam logic [31:0] RUN_RST = 32'h0000_0000;

	localparam int CNT_W = 16;
	localparam int OSC_N = 4;
	localparam int OSC_SETTLE_CYC = 10;

	// Keep only the implemented bits of a written word
	function automatic logic [31:0] keep_bits(input logic [31:0] w,
		input logic [31:0] m);
		keep_bits = w & m;
	endfunction
endpackage

// ### hw/tscr_osc_counter.sv
// One ring oscillator counter, counted in the core clock domain
`timescale 1ns/1ps
module tscr_osc_counter (
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic osc_i,
	output logic [tscr_pkg::CNT_W-1:0] count_o
);
	logic sync1_r;
	logic sync2_r;
	logic last_r;
	// Power-up count is zero; a system reset leaves it alone
	logic [tscr_pkg::CNT_W-1:0] count_r = {tscr_pkg::CNT_W{1'b0}};
	logic [tscr_pkg::CNT_W-1:0] count_nxt;

	// Two-stage synchroniser on the free-running oscillator line
	always_ff @(posedge clk_i) begin
		sync1_r <= osc_i;
		sync2_r <= sync1_r;
		last_r <= sync2_r;
	end

	always_comb begin
		count_nxt = count_r;
		if (run_i && sync2_r && !last_r) begin
			count_nxt = count_r + {{(tscr_pkg::CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// No reset here: the count survives a system reset
	always_ff @(posedge clk_i) begin
		count_r <= count_nxt;
	end

	assign count_o = count_r;

	chk_stop_stable: assert property (@(posedge clk_i)
		(!run_i)[*2] |=> $stable(count_r))
		else $error("counter moved while stopped");

	cov_osc_count: cover property (@(posedge clk_i)
		run_i && sync2_r && !last_r);
endmodule // tscr_osc_counter

// ### sim/tb_top.sv
// Self-checking bench for the tile status and control register bank
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic ps_wr_i = 1'b0;
	logic ps_rd_i = 1'b0;
	logic [7:0] ps_num_i = 8'h00;
	logic [31:0] ps_wdata_i = 32'h0000_0000;
	logic [31:0] ps_rdata_o;
	logic ps_rvalid_o;
	logic ps_werr_o;
	logic ev_take_i = 1'b0;
	logic [15:0] ev_vector_i = 16'h0000;
	logic [31:0] ev_target_o;
	logic ev_target_valid_o;
	logic [7:0] boot_proc_num_i = 8'h5a;
	logic [5:0] strap = 6'b101010;
	logic otp_load_i = 1'b0;
	logic [31:0] otp_word_i = 32'h0000_0000;
	logic [3:0] osc_line_i = 4'h0;
	wire logic [6:0] ctrl_out;
	wire logic [7:0] prot_out;
	wire logic [1:0] run_out;
	int fails = 0;
	int samples_checked = 0;
	logic [31:0] v;
	logic [31:0] base [4];
	logic [31:0] cw [4] = '{32'hffff_ffff, 32'h0000_0000, 32'h0000_0800, 32'h0000_1000};
	int pbit [7] = '{0, 4, 5, 7, 8, 9, 14};
	logic [1:0] rv [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
	logic [3:0] adv [4] = '{4'hf, 4'h3, 4'hc, 4'h0};

	always #2.5 clk_i = ~clk_i;

	tscr_regs u_tscr_regs (
		.clk_i(clk_i), .reset_i(reset_i), .ps_wr_i(ps_wr_i), .ps_rd_i(ps_rd_i),
		.ps_num_i(ps_num_i), .ps_wdata_i(ps_wdata_i), .ps_rdata_o(ps_rdata_o),
		.ps_rvalid_o(ps_rvalid_o), .ps_werr_o(ps_werr_o), .ev_take_i(ev_take_i),
		.ev_vector_i(ev_vector_i), .ev_target_o(ev_target_o),
		.ev_target_valid_o(ev_target_valid_o), .boot_proc_num_i(boot_proc_num_i),
		.boot_mode_override_i(strap[5]), .boot_no_otp_poll_i(strap[4]),
		.boot_from_ram_i(strap[3]), .boot_from_jtag_i(strap[2]),
		.boot_pll_pin_state_i(strap[1:0]), .otp_load_i(otp_load_i), .otp_word_i(otp_word_i),
		.osc_line_i(osc_line_i), .extmem_size_o(ctrl_out[6:5]), .ram_shutdown_o(ctrl_out[4]),
		.mem_autosleep_o(ctrl_out[3]), .mipi_ports_on_o(ctrl_out[2]),
		.pll_divider_on_o(ctrl_out[1]), .extmem_on_o(ctrl_out[0]),
		.block_global_debug_o(prot_out[2]), .block_pll_boot_jtag_o(prot_out[1]),
		.block_debug_tap_o(prot_out[0]), .block_otp_reads_o(prot_out[6]),
		.block_otp_program_o(prot_out[5]), .otp_single_space_o(prot_out[4]),
		.force_otp_boot_o(prot_out[3]), .protection_write_lock_o(prot_out[7]),
		.core_oscillator_run_o(run_out[1]), .peripheral_oscillator_run_o(run_out[0])
	);

	task summarize;
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, got);
			fails++;
		end
	endtask

	task wr(input logic [7:0] n, input logic [31:0] d, input logic err);
		logic seen;
		@(posedge clk_i);
		ps_wr_i <= 1'b1;
		ps_num_i <= n;
		ps_wdata_i <= d;
		@(posedge clk_i);
		ps_wr_i <= 1'b0;
		seen = 1'b0;
		repeat (2) begin
			#1 if (ps_werr_o === 1'b1) seen = 1'b1;
			@(posedge clk_i);
		end
		check("write_refused", {31'h0, err}, {31'h0, seen});
	endtask

	task rd(input logic [7:0] n, output logic [31:0] got);
		logic seen;
		@(posedge clk_i);
		ps_rd_i <= 1'b1;
		ps_num_i <= n;
		@(posedge clk_i);
		ps_rd_i <= 1'b0;
		seen = 1'b0;
		got = 32'hxxxx_xxxx;
		repeat (3) begin
			#1 if (!seen && ps_rvalid_o === 1'b1) begin
				seen = 1'b1;
				got = ps_rdata_o;
			end
			@(posedge clk_i);
		end
	endtask

	task rdc(input logic [7:0] n, input logic [31:0] exp, input string name);
		logic [31:0] got;
		rd(n, got);
		check(name, exp, got);
	endtask

	task ev(input logic [15:0] vec, input logic [31:0] exp);
		logic [31:0] got;
		@(posedge clk_i);
		ev_take_i <= 1'b1;
		ev_vector_i <= vec;
		@(posedge clk_i);
		ev_take_i <= 1'b0;
		got = 32'hxxxx_xxxx;
		repeat (3) begin
			#1 if (ev_target_valid_o === 1'b1) got = ev_target_o;
			@(posedge clk_i);
		end
		check("event_target", exp, got);
	endtask

	// Square pulses on the selected lines, each level held three clocks
	task pulse(input logic [3:0] m, input int n);
		repeat (n) begin
			repeat (3) @(posedge clk_i);
			osc_line_i <= m;
			repeat (3) @(posedge clk_i);
			osc_line_i <= 4'h0;
		end
		repeat (4) @(posedge clk_i);
	endtask

	function automatic logic [31:0] boot_exp();
		return {8'h00, boot_proc_num_i, 7'h00, strap[5], 3'h0, strap[4:2], strap[1:0]};
	endfunction

	function automatic logic [31:0] cexp(input logic [31:0] w);
		return {25'h0, w[12:11], w[10], w[9], w[8], w[4], w[0]};
	endfunction

	function automatic logic [31:0] pexp(input logic [31:0] w);
		return {24'h0, w[31], w[9], w[8], w[7], w[5], w[14], w[4], w[0]};
	endfunction

	initial begin
		repeat (30000) @(posedge clk_i);
		fails++;
		summarize();
	end

	initial begin
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		rdc(tscr_pkg::NUM_VEC_BASE, 32'h0, "vec_reset");
		rdc(tscr_pkg::NUM_TILE_CTRL, 32'h0000_1800, "ctrl_reset");
		check("ctrl_pins_reset", 32'h0000_0060, {25'h0, ctrl_out});
		rdc(tscr_pkg::NUM_PROTECT, 32'h0, "prot_reset");
		rdc(tscr_pkg::NUM_OSC_RUN, 32'h0, "run_reset");
		rdc(tscr_pkg::NUM_BOOT_STATE, boot_exp(), "boot_state");
		wr(tscr_pkg::NUM_BOOT_STATE, 32'hffff_ffff, 1'b1);
		rdc(tscr_pkg::NUM_BOOT_STATE, boot_exp(), "boot_after_write");
		wr(8'h04, 32'hffff_ffff, 1'b1);
		rdc(8'h04, 32'h0, "unmapped");
		wr(tscr_pkg::NUM_OSC_CNT0, 32'h0, 1'b1);
		wr(tscr_pkg::NUM_VEC_BASE, 32'hffff_ffff, 1'b0);
		rdc(tscr_pkg::NUM_VEC_BASE, 32'hfff8_0000, "vec_mask");
		ev(16'h1234, 32'hfff8_1234);
		wr(tscr_pkg::NUM_VEC_BASE, 32'ha5a5_5a5a, 1'b0);
		ev(16'hbeef, 32'ha5a0_beef);
		for (int t = 0; t < 4; t++) begin
			wr(tscr_pkg::NUM_TILE_CTRL, cw[t], 1'b0);
			rdc(tscr_pkg::NUM_TILE_CTRL, cw[t] & 32'h0000_1f11, "ctrl");
			check("ctrl_pins", cexp(cw[t]), {25'h0, ctrl_out});
		end
		for (int b = 0; b < 7; b++) begin
			wr(tscr_pkg::NUM_PROTECT, 32'h1 << pbit[b], 1'b0);
			rdc(tscr_pkg::NUM_PROTECT, 32'h1 << pbit[b], "prot_bit");
			check("prot_pins", pexp(32'h1 << pbit[b]), {24'h0, prot_out});
		end
		wr(tscr_pkg::NUM_PROTECT, 32'hffff_ffff, 1'b0);
		rdc(tscr_pkg::NUM_PROTECT, 32'h8000_43b1, "prot_all");
		wr(tscr_pkg::NUM_PROTECT, 32'h0, 1'b1);
		rdc(tscr_pkg::NUM_PROTECT, 32'h8000_43b1, "prot_locked");
		check("prot_pins_locked", pexp(32'h8000_43b1), {24'h0, prot_out});
		@(posedge clk_i);
		otp_load_i <= 1'b1;
		otp_word_i <= 32'h7fff_fe5e;
		@(posedge clk_i);
		otp_load_i <= 1'b0;
		rdc(tscr_pkg::NUM_PROTECT, 32'h0000_4210, "prot_otp");
		check("prot_pins_otp", pexp(32'h0000_4210), {24'h0, prot_out});
		// Move the counters off their power-up value
		wr(tscr_pkg::NUM_OSC_RUN, 32'h3, 1'b0);
		pulse(4'hf, 2);
		wr(tscr_pkg::NUM_OSC_RUN, 32'h0, 1'b0);
		repeat (10) @(posedge clk_i);
		for (int i = 0; i < 4; i++) begin
			rd(tscr_pkg::NUM_OSC_CNT0 + 8'(i), base[i]);
			check("count_upper", 32'h0, base[i] & 32'hffff_0000);
		end
		for (int t = 0; t < 4; t++) begin
			wr(tscr_pkg::NUM_OSC_RUN, 32'hffff_fffc | {30'h0, rv[t]}, 1'b0);
			check("run_pins", {30'h0, rv[t]}, {30'h0, run_out});
			rdc(tscr_pkg::NUM_OSC_RUN, {30'h0, rv[t]}, "run_reg");
			pulse(4'hf, 5);
			wr(tscr_pkg::NUM_OSC_RUN, 32'h0, 1'b0);
			repeat (10) @(posedge clk_i);
			for (int i = 0; i < 4; i++) begin
				rd(tscr_pkg::NUM_OSC_CNT0 + 8'(i), v);
				check("count", {16'h0, base[i][15:0] + (adv[t][i] ? 16'h5 : 16'h0)}, v);
				base[i] = v;
			end
		end
		pulse(4'hf, 3);
		rdc(tscr_pkg::NUM_OSC_CNT1, base[1], "count_stopped");
		@(posedge clk_i);
		reset_i <= 1'b1;
		strap <= 6'b010101;
		boot_proc_num_i <= 8'h3c;
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		rdc(tscr_pkg::NUM_BOOT_STATE, boot_exp(), "boot_resampled");
		rdc(tscr_pkg::NUM_TILE_CTRL, 32'h0000_1800, "ctrl_rereset");
		for (int i = 0; i < 4; i++) begin
			rdc(tscr_pkg::NUM_OSC_CNT0 + 8'(i), base[i], "count_kept");
		end
		summarize();
	end
endmodule // tb_top
